// ===== core/phy_event_flag_bank.sv
//
// Summary of operation
// - latch negotiation error on fault, mismatch, lost link
// - latch speed change until cause read
// - latch duplex change until cause read
// - page received is live status, not latched
// - negotiation complete is live status
// - latch link state change until cause read
// - latch false carrier until cause read
// - latch crossover change; bit 7 reads zero
// - latch speed downgrade until cause read
// - energy detect change bit always zero
// - latch polarity change and jabber until read
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none

module phy_event_flag_bank (
   input wire logic clk,
   input wire logic rst,
   input wire logic clk_en,
   // register port
   input wire logic [4:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   // event sources, same clock domain
   input wire logic an_parallel_fault,
   input wire logic an_no_shared_best_ability,
   input wire logic an_complete,
   input wire logic page_received,
   input wire logic link_up,
   input wire logic speed_100,
   input wire logic full_duplex,
   input wire logic mdi_crossed,
   input wire logic rx_pol_inverted,
   input wire logic symbol_error,
   input wire logic false_carrier,
   input wire logic speed_downgrade,
   input wire logic jabber_detect,
   // interrupt line
   output logic event_irq
);

   // ***********************************************
   // state
   // ***********************************************
   typedef struct packed {
      logic [15:0] mask;
      logic [15:0] rdata;
      logic irq;
      logic prime;
      logic spd;
      logic dpx;
      logic link;
      logic xover;
      logic pol;
   } top_state_t;

   top_state_t st_q;
   top_state_t st_d;
   logic [15:0] cause_view;
   logic cause_rd;
   logic mask_wr;

   flag_if #(.W(16)) fl ();

   flag_bank #(
      .W(16)
   ) u_flags (
      .clk(clk),
      .rst(rst),
      .fl(fl)
   );

   // ***********************************************
   // decode
   // ***********************************************
   assign cause_rd = clk_en && reg_rd && (reg_addr == evt_pkg::CAUSE_OFF);
   assign mask_wr = clk_en && reg_wr && (reg_addr == evt_pkg::MASK_OFF);

   // cause as software sees it: latched bits plus two live levels
   always_comb begin
      cause_view = fl.flags & evt_pkg::LATCH_BITS;
      cause_view[evt_pkg::B_PAGE] = page_received;
      cause_view[evt_pkg::B_ANEG_DONE] = an_complete;
   end

   // ***********************************************
   // event detection
   // ***********************************************
   // change detectors wait one cycle after reset, so a line that is
   // already up at release does not report a false change
   always_comb begin
      fl.clk_en = clk_en;
      fl.set = '0;
      fl.clr = '0;
      if (clk_en) begin
         fl.set[evt_pkg::B_ANEG_ERR] = an_parallel_fault | an_no_shared_best_ability
            | (st_q.prime & an_complete & st_q.link & ~link_up);
         fl.set[evt_pkg::B_SPEED] = st_q.prime & (speed_100 ^ st_q.spd);
         fl.set[evt_pkg::B_DUPLEX] = st_q.prime & (full_duplex ^ st_q.dpx);
         fl.set[evt_pkg::B_LINK] = st_q.prime & (link_up ^ st_q.link);
         fl.set[evt_pkg::B_SYMBOL] = symbol_error;
         fl.set[evt_pkg::B_FALSE_CAR] = false_carrier;
         fl.set[evt_pkg::B_XOVER] = st_q.prime & (mdi_crossed ^ st_q.xover);
         fl.set[evt_pkg::B_DOWNGRADE] = speed_downgrade;
         fl.set[evt_pkg::B_POLARITY] = st_q.prime & (rx_pol_inverted ^ st_q.pol);
         fl.set[evt_pkg::B_JABBER] = jabber_detect;
         if (cause_rd) begin
            fl.clr = evt_pkg::LATCH_BITS;
         end
      end
   end

   // ***********************************************
   // registers and read path
   // ***********************************************
   // read data stand for one enabled cycle and are zero after it; while clk_en is low they hold
   always_comb begin
      st_d = st_q;
      if (clk_en) begin
         st_d.prime = 1'b1;
         st_d.spd = speed_100;
         st_d.dpx = full_duplex;
         st_d.link = link_up;
         st_d.xover = mdi_crossed;
         st_d.pol = rx_pol_inverted;
         st_d.rdata = evt_pkg::RDATA_RESET;
         if (reg_rd) begin
            case (reg_addr)
               evt_pkg::MASK_OFF: begin
                  st_d.rdata = st_q.mask;
               end
               evt_pkg::CAUSE_OFF: begin
                  st_d.rdata = cause_view;
               end
               default: begin
                  st_d.rdata = evt_pkg::RDATA_RESET;
               end
            endcase
         end
         if (mask_wr) begin
            st_d.mask = reg_wdata & evt_pkg::MASK_WRITABLE;
         end
         st_d.irq = |(cause_view & st_q.mask);
      end
   end

   // only the hardware reset touches these; there is no soft path in
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q.mask <= evt_pkg::MASK_RESET;
         st_q.rdata <= evt_pkg::RDATA_RESET;
         st_q.irq <= 1'b0;
         st_q.prime <= 1'b0;
         st_q.spd <= 1'b0;
         st_q.dpx <= 1'b0;
         st_q.link <= 1'b0;
         st_q.xover <= 1'b0;
         st_q.pol <= 1'b0;
      end else begin
         st_q <= st_d;
      end
   end

   assign reg_rdata = st_q.rdata;
   assign event_irq = st_q.irq;

   // ***********************************************
   // checks
   // ***********************************************
   // the interrupt sum built again from flags, live levels and enables, so the
   // gate check below does not just repeat the expression it guards
   logic irq_expect;
   assign irq_expect = |(fl.flags & evt_pkg::LATCH_BITS & st_q.mask)
      | (page_received & st_q.mask[evt_pkg::B_PAGE])
      | (an_complete & st_q.mask[evt_pkg::B_ANEG_DONE]);

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   sequence s_cause_read;
      clk_en && reg_rd && (reg_addr == evt_pkg::CAUSE_OFF);
   endsequence

   sequence s_quiet_cycle;
      clk_en && !cause_rd;
   endsequence

   a_aneg_err_set: assert property (
      clk_en && (an_parallel_fault || an_no_shared_best_ability)
      |=> fl.flags[evt_pkg::B_ANEG_ERR])
      else $error("negotiation error not latched");

   a_speed_latch: assert property (
      clk_en && st_q.prime && (speed_100 != st_q.spd) |=> fl.flags[evt_pkg::B_SPEED])
      else $error("speed change not latched");

   a_duplex_latch: assert property (
      clk_en && st_q.prime && (full_duplex != st_q.dpx)
      ##1 s_quiet_cycle |=> fl.flags[evt_pkg::B_DUPLEX])
      else $error("duplex change not held");

   a_page_live: assert property (
      s_cause_read |=> reg_rdata[evt_pkg::B_PAGE] == $past(page_received))
      else $error("page received not live");

   a_done_live: assert property (
      s_cause_read |=> reg_rdata[evt_pkg::B_ANEG_DONE] == $past(an_complete))
      else $error("negotiation complete not live");

   a_link_hold: assert property (
      (fl.flags[evt_pkg::B_LINK] and s_quiet_cycle) |=> fl.flags[evt_pkg::B_LINK])
      else $error("link change dropped without read");

   a_symbol_latch: assert property (
      clk_en && symbol_error ##1 s_cause_read |=> reg_rdata[evt_pkg::B_SYMBOL])
      else $error("symbol error not reported");

   a_false_car: assert property (
      clk_en && false_carrier |=> fl.flags[evt_pkg::B_FALSE_CAR])
      else $error("false carrier not latched");

   a_xover_rsvd7: assert property (
      s_cause_read |=> !reg_rdata[evt_pkg::B_RSVD7])
      else $error("reserved bit 7 reads one");

   a_downgrade_clear: assert property (
      (s_cause_read and !speed_downgrade) |=> !fl.flags[evt_pkg::B_DOWNGRADE])
      else $error("downgrade flag survived read");

   a_energy_zero: assert property (
      s_cause_read |=> !reg_rdata[evt_pkg::B_ENERGY])
      else $error("energy detect bit reads one");

   a_jabber_latch: assert property (
      clk_en && jabber_detect |=> fl.flags[evt_pkg::B_JABBER])
      else $error("jabber not latched");

   a_irq_gate: assert property (
      clk_en |=> event_irq == $past(irq_expect))
      else $error("interrupt not gated by enables");

   a_mask_rsvd: assert property (
      mask_wr |=> st_q.mask == ($past(reg_wdata) & evt_pkg::MASK_WRITABLE)
      && st_q.mask[3:2] == 2'h0)
      else $error("enable write wrong or reserved bits set");

   a_reset_clear: assert property (@(posedge clk)
      $fell(rst) |-> (st_q.mask == evt_pkg::MASK_RESET) && (fl.flags == evt_pkg::CAUSE_RESET))
      else $error("registers not cleared by reset");

   // latched causes ride out quiet cycles; only a cause read may drop them
   a_aneg_hold: assert property (
      (fl.flags[evt_pkg::B_ANEG_ERR] and s_quiet_cycle) |=> fl.flags[evt_pkg::B_ANEG_ERR])
      else $error("negotiation error dropped without read");

   a_speed_hold: assert property (
      (fl.flags[evt_pkg::B_SPEED] and s_quiet_cycle) |=> fl.flags[evt_pkg::B_SPEED])
      else $error("speed change dropped without read");

   a_symbol_hold: assert property (
      (fl.flags[evt_pkg::B_SYMBOL] and s_quiet_cycle) |=> fl.flags[evt_pkg::B_SYMBOL])
      else $error("symbol error dropped without read");

   a_false_hold: assert property (
      (fl.flags[evt_pkg::B_FALSE_CAR] and s_quiet_cycle) |=> fl.flags[evt_pkg::B_FALSE_CAR])
      else $error("false carrier dropped without read");

   a_jabber_hold: assert property (
      (fl.flags[evt_pkg::B_JABBER] and s_quiet_cycle) |=> fl.flags[evt_pkg::B_JABBER])
      else $error("jabber dropped without read");

   // change detectors, the link loss error, the enables and the reset values
   a_link_loss_err: assert property (
      clk_en && st_q.prime && an_complete && st_q.link && !link_up
      |=> fl.flags[evt_pkg::B_ANEG_ERR])
      else $error("link loss after negotiation not latched");

   a_xover_latch: assert property (
      clk_en && st_q.prime && (mdi_crossed != st_q.xover) |=> fl.flags[evt_pkg::B_XOVER])
      else $error("crossover change not latched");

   a_pol_latch: assert property (
      clk_en && st_q.prime && (rx_pol_inverted != st_q.pol) |=> fl.flags[evt_pkg::B_POLARITY])
      else $error("polarity change not latched");

   a_mask_hold: assert property (
      !mask_wr |=> $stable(st_q.mask))
      else $error("enables moved without a write");

   a_mask_read: assert property (
      clk_en && reg_rd && (reg_addr == evt_pkg::MASK_OFF) |=> reg_rdata == $past(st_q.mask))
      else $error("enable read back wrong");

   a_cause_rsvd: assert property (
      s_cause_read |=> reg_rdata[3:2] == 2'h0)
      else $error("reserved cause bits read one");

   a_irq_reset: assert property (@(posedge clk)
      $fell(rst) |-> !event_irq && (reg_rdata == evt_pkg::RDATA_RESET))
      else $error("line or read data not cleared by reset");

endmodule

`default_nettype wire

// ===== core/evt_pkg.sv
package evt_pkg;

   // ***********************************************
   // register map
   // ***********************************************
   localparam int ADDR_W = 5;
   localparam int DATA_W = 16;
   localparam logic [4:0] MASK_OFF = 5'h12;
   localparam logic [4:0] CAUSE_OFF = 5'h13;

   // ***********************************************
   // reset values and bit classes
   // ***********************************************
   localparam logic [15:0] MASK_RESET = 16'h0000;
   localparam logic [15:0] CAUSE_RESET = 16'h0000;
   localparam logic [15:0] RDATA_RESET = 16'h0000;
   // enable bits that take a write: all but the reserved pair 3:2
   localparam logic [15:0] MASK_WRITABLE = 16'hfff3;
   // cause bits that latch high until the cause register is read
   localparam logic [15:0] LATCH_BITS = 16'he763;

   // ***********************************************
   // field positions in both registers
   // ***********************************************
   localparam int B_ANEG_ERR = 15;
   localparam int B_SPEED = 14;
   localparam int B_DUPLEX = 13;
   localparam int B_PAGE = 12;
   localparam int B_ANEG_DONE = 11;
   localparam int B_LINK = 10;
   localparam int B_SYMBOL = 9;
   localparam int B_FALSE_CAR = 8;
   localparam int B_RSVD7 = 7;
   localparam int B_XOVER = 6;
   localparam int B_DOWNGRADE = 5;
   localparam int B_ENERGY = 4;
   localparam int B_POLARITY = 1;
   localparam int B_JABBER = 0;

endpackage

// ===== core/flag_if.sv
`timescale 1ns/10ps
`default_nettype none

// ***********************************************
// set/clear/flag carrier between top and flag bank
// ***********************************************
interface flag_if #(
   parameter int W = 16
);
   logic clk_en;
   logic [W-1:0] set;
   logic [W-1:0] clr;
   logic [W-1:0] flags;

   modport bank (input clk_en, input set, input clr, output flags);
   modport user (output clk_en, output set, output clr, input flags);
endinterface

`default_nettype wire

// ===== core/flag_bank.sv
`timescale 1ns/10ps
`default_nettype none

// ***********************************************
// bank of latched-high flags
// ***********************************************
module flag_bank #(
   parameter int W = 16
) (
   input wire logic clk,
   input wire logic rst,
   flag_if.bank fl
);

   typedef struct packed {
      logic [W-1:0] flags;
   } bank_state_t;

   bank_state_t st_q;
   bank_state_t st_d;

   // set beats clear so an event landing on the read is kept for the next one
   always_comb begin
      st_d = st_q;
      if (fl.clk_en) begin
         st_d.flags = fl.set | (st_q.flags & ~fl.clr);
      end
   end

   // flags only ever clear on a hardware reset or on a read
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign fl.flags = st_q.flags;

   // ***********************************************
   // checks
   // ***********************************************
   a_set_wins_clear: assert property (@(posedge clk) disable iff (rst)
      fl.clk_en |=> ((st_q.flags & $past(fl.set)) == $past(fl.set)))
      else $error("flag lost while being set");

   a_freeze_holds: assert property (@(posedge clk) disable iff (rst)
      !fl.clk_en |=> $stable(st_q.flags))
      else $error("flags moved with clock enable low");

endmodule

`default_nettype wire

// ===== dv/phy_event_flag_bank_tb.sv
`timescale 1ns/10ps
`default_nettype none

module phy_event_flag_bank_tb;
   // *******************
   // stimulus and dut
   // *******************
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic clk_en = 1'b1;
   logic [4:0] reg_addr = 5'h00;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [15:0] reg_rdata;
   logic an_complete = 1'b0;
   logic page_received = 1'b0;
   logic [10:0] src = 11'h000;
   logic event_irq;
   int failures = 0;
   int cmp_count = 0;
   // cause bit expected for each src line, same order as the port list below
   int bitpos [11] = '{15, 15, 10, 14, 13, 6, 1, 9, 8, 5, 0};

   // free-running 50 MHz clock
   always #10 clk = ~clk;

   phy_event_flag_bank DUT (
      .clk(clk),
      .rst(rst),
      .clk_en(clk_en),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_rdata(reg_rdata),
      .an_parallel_fault(src[0]),
      .an_no_shared_best_ability(src[1]),
      .an_complete(an_complete),
      .page_received(page_received),
      .link_up(src[2]),
      .speed_100(src[3]),
      .full_duplex(src[4]),
      .mdi_crossed(src[5]),
      .rx_pol_inverted(src[6]),
      .symbol_error(src[7]),
      .false_carrier(src[8]),
      .speed_downgrade(src[9]),
      .jabber_detect(src[10]),
      .event_irq(event_irq)
   );

   // *******************
   // access tasks
   // *******************
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   // read data stand one cycle only, so the idle cycle after is checked too
   task automatic rd(input logic [4:0] a, input logic [15:0] exp, input string what);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk(what, exp, reg_rdata);
      @(posedge clk);
      #1;
      chk("rdata idle", 16'h0000, reg_rdata);
   endtask

   // two changes of a level, or a one-cycle pulse of a strobe
   task automatic toggle(input int i);
      @(posedge clk);
      src[i] <= ~src[i];
      @(posedge clk);
      src[i] <= ~src[i];
   endtask

   task automatic irq_is(input logic exp);
      @(posedge clk);
      #1;
      chk("event_irq", {15'h0000, exp}, {15'h0000, event_irq});
   endtask

   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // *******************
   // scenarios
   // *******************
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      rd(5'h12, 16'h0000, "mask reset");
      rd(5'h13, 16'h0000, "cause reset");
      // reserved enable pair never takes a write
      wr(5'h12, 16'hffff);
      rd(5'h12, 16'hfff3, "mask ones");
      wr(5'h12, 16'h000c);
      rd(5'h12, 16'h0000, "mask reserved");
      wr(5'h13, 16'hffff);
      rd(5'h13, 16'h0000, "cause write");
      rd(5'h05, 16'h0000, "unmapped");
      // each source latches exactly its own bit; one read clears it
      for (int i = 0; i < 11; i++) begin
         toggle(i);
         rd(5'h13, 16'h0001 << bitpos[i], "cause set");
         rd(5'h13, 16'h0000, "cause clear");
      end
      // a frozen clock enable must not see events
      @(posedge clk);
      clk_en <= 1'b0;
      toggle(7);
      @(posedge clk);
      clk_en <= 1'b1;
      rd(5'h13, 16'h0000, "frozen");
      // live status bits follow their inputs and survive a read
      @(posedge clk);
      an_complete <= 1'b1;
      rd(5'h13, 16'h0800, "aneg done");
      rd(5'h13, 16'h0800, "aneg done held");
      @(posedge clk);
      page_received <= 1'b1;
      rd(5'h13, 16'h1800, "page live");
      @(posedge clk);
      page_received <= 1'b0;
      rd(5'h13, 16'h0800, "page gone");
      // link loss after completed negotiation is an error
      @(posedge clk);
      src[2] <= 1'b1;
      rd(5'h13, 16'h0c00, "link up");
      @(posedge clk);
      src[2] <= 1'b0;
      rd(5'h13, 16'h8c00, "link lost");
      // a pending flag reaches the line only once enabled
      toggle(10);
      irq_is(1'b0);
      wr(5'h12, 16'h0001);
      irq_is(1'b1);
      rd(5'h13, 16'h0801, "jabber");
      irq_is(1'b0);
      wr(5'h12, 16'h0800);
      irq_is(1'b1);
      // a downgrade landing on the clearing read must survive that read
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= 5'h13;
      src[9] <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      src[9] <= 1'b0;
      #1;
      chk("read beside event", 16'h0800, reg_rdata);
      rd(5'h13, 16'h0820, "set beats clear");
      // hardware reset in mid-run wipes enables and flags
      wr(5'h12, 16'hffff);
      toggle(7);
      @(posedge clk);
      an_complete <= 1'b0;
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      irq_is(1'b0);
      repeat (2) @(posedge clk);
      rd(5'h12, 16'h0000, "mask after reset");
      rd(5'h13, 16'h0000, "cause after reset");
      end_of_test();
   end

   // cuts a hang short
   initial begin
      #200000;
      failures++;
      end_of_test();
   end
endmodule

`default_nettype wire
